/* File: hw/pmd_top.sv */
// Purpose: master duty and protection key registers with one duty generator
// Assumes: classic wishbone slave, 32-bit data, one cycle per access
// Notes: unmapped reads return zero and are still acknowledged
// Notes on behaviour
// RULE1 - a 16-bit read/write master duty register, zero at reset, sets the generator pulse width.
// RULE2 - the narrowest pulse matches a duty of 0x0008; smaller values give no narrower pulse.
// RULE3 - the widest pulse matches period minus 0x0008; larger values widen it no further; the code rounds that down to a multiple of 4 lsb.
// RULE4 - within about 40 ns of 0 or 100 percent the duty resolution coarsens from 1 to 3 lsb; the code steps by 2 lsb there, and by 4 lsb within 20 ns.
// RULE5 - a 16-bit read/write protection key register, zero at reset, holds lock or unlock keys.
// RULE6 - the output is active while the period counter is below the duty and inactive after.
`timescale 1ns/1ps
module pmd_top (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic pwm_out
);
	logic [15:0] duty_reg, duty_next;
	logic [15:0] key_reg, key_next;
	logic [15:0] period_reg, period_next;
	logic en_reg, en_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic pwm_reg;
	logic req;
	logic [15:0] wmask;

	pmd_duty_if dif ();

	assign dif.period = period_reg;
	assign dif.duty = duty_reg; // [RULE1]
	assign dif.enable = en_reg;

	pmd_gen u_gen (
		.ref_clk(ref_clk),
		.srst(srst),
		.dif(dif)
	);

	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb begin
		duty_next = duty_reg;
		key_next = key_reg;
		period_next = period_reg;
		en_next = en_reg;
		ack_next = req;
		rdat_next = 32'h00000000;
		if (req && wb_we_i) begin
			unique case (wb_adr_i)
				pmd_pkg::OFS_MASTER_DUTY: begin
					duty_next = (duty_reg & ~wmask) | (wb_dat_i[15:0] & wmask); // [RULE1]
				end
				pmd_pkg::OFS_PROT_KEY: begin
					key_next = (key_reg & ~wmask) | (wb_dat_i[15:0] & wmask); // [RULE5]
				end
				pmd_pkg::OFS_PERIOD: begin
					period_next = (period_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
				end
				pmd_pkg::OFS_CONTROL: begin
					if (wb_sel_i[0]) begin
						en_next = wb_dat_i[0];
					end
				end
				default: begin
				end
			endcase
		end
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				pmd_pkg::OFS_MASTER_DUTY: rdat_next = {16'h0000, duty_reg}; // [RULE1]
				pmd_pkg::OFS_PROT_KEY: rdat_next = {16'h0000, key_reg}; // [RULE5]
				pmd_pkg::OFS_PERIOD: rdat_next = {16'h0000, period_reg};
				pmd_pkg::OFS_CONTROL: rdat_next = {31'h00000000, en_reg};
				pmd_pkg::OFS_STATUS: rdat_next = {15'h0000, dif.pwm_out, dif.count};
				default: rdat_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			duty_reg <= pmd_pkg::RST_MASTER_DUTY;
			key_reg <= pmd_pkg::RST_PROT_KEY;
			period_reg <= pmd_pkg::RST_PERIOD;
			en_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
			pwm_reg <= 1'b0;
		end else begin
			duty_reg <= duty_next;
			key_reg <= key_next;
			period_reg <= period_next;
			en_reg <= en_next;
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			pwm_reg <= dif.pwm_out;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign pwm_out = pwm_reg;
endmodule : pmd_top

/* File: hw/pmd_pkg.sv */
// Purpose: shared constants for the master duty and protection key block
// Assumes: 32-bit classic wishbone, word-aligned registers
// Notes: offsets are byte addresses
package pmd_pkg;
	localparam int DATA_W = 16;
	localparam logic [7:0] OFS_MASTER_DUTY = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_PROT_KEY = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [15:0] RST_MASTER_DUTY = 16'h0000;
	localparam logic [15:0] RST_PROT_KEY = 16'h0000;
	localparam logic [15:0] RST_PERIOD = 16'hffff;
	localparam logic [15:0] PULSE_MARGIN = 16'h0008;
	localparam logic [15:0] FINE_LIMIT_NS = 16'h0028;
	localparam int CLK_PERIOD_NS = 4;
	// window near 0 or 100 percent, in counts
	localparam logic [15:0] FINE_LIMIT_CNT = 16'(40 / CLK_PERIOD_NS);
	localparam logic [1:0] COARSE_MASK_MID = 2'h1;
	localparam logic [1:0] COARSE_MASK_EDGE = 2'h3;
endpackage : pmd_pkg

/* File: hw/pmd_duty_if.sv */
// Purpose: carries period, duty and count between the top and the generator
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface pmd_duty_if;
	logic [15:0] period;
	logic [15:0] duty;
	logic enable;
	logic [15:0] count;
	logic pwm_out;
	modport ctrl (output period, output duty, output enable, input count, input pwm_out);
	modport gen (input period, input duty, input enable, output count, output pwm_out);
endinterface : pmd_duty_if

/* File: hw/pmd_gen.sv */
// Purpose: one generator using the master duty source
// Assumes: duty and period stable per cycle
// Notes: clamps duty to the producible pulse range
`timescale 1ns/1ps
module pmd_gen (
	input wire logic ref_clk,
	input wire logic srst,
	pmd_duty_if.gen dif
);
	logic [15:0] cnt_reg, cnt_next;
	logic out_reg, out_next;
	logic [15:0] eff;
	logic [15:0] hi_lim;
	logic [15:0] lo_dist;
	logic [15:0] hi_dist;
	logic [15:0] lat_reg, lat_next;
	logic [15:0] eff_use;

	always_comb begin
		hi_lim = dif.period - pmd_pkg::PULSE_MARGIN;
		eff = dif.duty;
		if (eff < pmd_pkg::PULSE_MARGIN) begin
			eff = pmd_pkg::PULSE_MARGIN; // [RULE2]
		end
		if (eff > hi_lim) begin
			eff = hi_lim; // [RULE3]
		end
		lo_dist = eff - pmd_pkg::PULSE_MARGIN;
		hi_dist = hi_lim - eff;
		// resolution coarsens to 4 lsb inside half the edge window, 2 lsb in the rest of it
		if (lo_dist < (pmd_pkg::FINE_LIMIT_CNT >> 1) || hi_dist < (pmd_pkg::FINE_LIMIT_CNT >> 1)) begin
			eff = eff & ~{14'h0000, pmd_pkg::COARSE_MASK_EDGE}; // [RULE4]
		end else if (lo_dist < pmd_pkg::FINE_LIMIT_CNT || hi_dist < pmd_pkg::FINE_LIMIT_CNT) begin
			eff = eff & ~{14'h0000, pmd_pkg::COARSE_MASK_MID}; // [RULE4]
		end
		if (eff < pmd_pkg::PULSE_MARGIN) begin
			eff = pmd_pkg::PULSE_MARGIN; // [RULE2]
		end
		cnt_next = cnt_reg;
		out_next = 1'b0;
		if (dif.enable) begin
			cnt_next = (cnt_reg >= dif.period) ? 16'h0000 : cnt_reg + 16'h0001;
		end else begin
			// park at the wrap point so the first enabled cycle opens a whole period
			cnt_next = dif.period;
		end
		// a new duty takes effect only at period start, so no runt pulse can appear
		eff_use = (cnt_next == 16'h0000 || !dif.enable) ? eff : lat_reg; // [RULE2] [RULE3]
		lat_next = eff_use;
		if (dif.enable) begin
			out_next = (cnt_next < eff_use); // [RULE6]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_reg <= 16'h0000;
			out_reg <= 1'b0;
			lat_reg <= pmd_pkg::PULSE_MARGIN;
		end else begin
			cnt_reg <= cnt_next;
			out_reg <= out_next;
			lat_reg <= lat_next;
		end
	end

	assign dif.count = cnt_reg;
	assign dif.pwm_out = out_reg;
endmodule : pmd_gen

/* File: verif/pmd_checker.sv */
// Purpose: bus and pulse timing checks on pmd_top
// Assumes: one clock, srst synchronous
// Notes: bound below
`timescale 1ns/1ps
module pmd_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic pwm_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_one: assert property (p_one) else $error("ack held");
	property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_cause: assert property (p_cause) else $error("ack unasked");
	property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data without ack");
	property p_up; wb_ack_o |-> wb_dat_o[31:17] == 15'h0 &&
		($past(wb_adr_i) == pmd_pkg::OFS_STATUS || !wb_dat_o[16]); endproperty
	a_up: assert property (p_up) else $error("upper bits set");
	property p_hi; $rose(pwm_out) |=> pwm_out [*7]; endproperty
	a_hi: assert property (p_hi) else $error("pulse too narrow");
	property p_lo; $fell(pwm_out) |=> !pwm_out [*7]; endproperty
	a_lo: assert property (p_lo) else $error("pulse too wide");
endmodule : pmd_checker
bind pmd_top pmd_checker u_chk (.ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .pwm_out);

/* File: verif/pwm_master_duty_and_key_test.sv */
// Purpose: directed bench for pmd_top
// Assumes: 250 MHz clock, one access at a time
// Notes: period 0x40 keeps pulse runs short
`timescale 1ns/1ps
module pwm_master_duty_and_key_test;
	logic ref_clk = 1'b0, srst = 1'b1, cyc = 1'b0, we = 1'b0, ack, pwm;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h3, sel_m = 4'h3;
	logic [31:0] di = 32'h0, dq, rd;
	int errors = 0, num_checks = 0;
	always #2 ref_clk = ~ref_clk;
	pmd_top dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dq), .wb_ack_o(ack),
		.pwm_out(pwm));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		sel <= sel_m;
		adr <= a;
		di <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1);
		rd = dq;
		// taken at the first edge, ack seen high at the second
		chk("ack wait", 32'h2, 32'(n));
		cyc <= 1'b0;
		@(posedge ref_clk);
	endtask : bus
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		bus(1'b1, a, d);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rd);
	endtask : wr_rd
	task automatic width(input logic [31:0] d, input logic [31:0] e);
		int n;
		n = 0;
		bus(1'b1, pmd_pkg::OFS_MASTER_DUTY, d);
		repeat (140) @(posedge ref_clk);
		while (pwm === 1'b1 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		while (pwm !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		n = 0;
		while (pwm === 1'b1 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		chk($sformatf("width %h", d), e, 32'(n));
	endtask : width
	task automatic t_regs;
		bus(1'b0, pmd_pkg::OFS_MASTER_DUTY, 32'h0);
		chk("duty reset", 32'h0, rd);
		bus(1'b0, pmd_pkg::OFS_PROT_KEY, 32'h0);
		chk("key reset", 32'h0, rd);
		bus(1'b0, pmd_pkg::OFS_PERIOD, 32'h0);
		chk("period reset", 32'h0000ffff, rd);
		wr_rd(pmd_pkg::OFS_MASTER_DUTY, 32'hffffa5c3, 32'h0000a5c3);
		wr_rd(pmd_pkg::OFS_PROT_KEY, 32'h96695a3c, 32'h00005a3c);
		wr_rd(8'h40, 32'h1234, 32'h0);
		bus(1'b0, pmd_pkg::OFS_MASTER_DUTY, 32'h0);
		chk("duty kept", 32'h0000a5c3, rd);
		sel_m = 4'h1;
		bus(1'b1, pmd_pkg::OFS_MASTER_DUTY, 32'h00001177);
		sel_m = 4'h3;
		bus(1'b0, pmd_pkg::OFS_MASTER_DUTY, 32'h0);
		chk("duty low lane", 32'h0000a577, rd);
		$display("test regs done");
	endtask : t_regs
	task automatic t_pwm;
		bus(1'b1, pmd_pkg::OFS_PERIOD, 32'h40);
		bus(1'b1, pmd_pkg::OFS_CONTROL, 32'h1);
		width(32'h21, 32'h21);
		width(32'h2, 32'h8);
		width(32'h9, 32'h8);
		width(32'hfff0, 32'h38);
		width(32'hf, 32'he);
		width(32'h37, 32'h34);
		bus(1'b0, pmd_pkg::OFS_CONTROL, 32'h0);
		chk("enable", 32'h1, rd);
		bus(1'b0, pmd_pkg::OFS_STATUS, 32'h0);
		chk("status top", 32'h0, 32'(rd[31:17]));
		chk("count range", 32'h1, 32'(rd[15:0] <= 16'h0040));
		$display("test pwm done");
	endtask : t_pwm
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_pwm();
		tally_and_finish();
	end
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
endmodule : pwm_master_duty_and_key_test
